// [hw/gsr_pkg.sv]
package gsr_pkg;
  // ***************************************
  // Timing
  // ***************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_HZ = 4;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int OVL_HOLD_MS = 500;
  localparam int OVL_HOLD_CYC = (CLK_HZ / 1000) * OVL_HOLD_MS;
  localparam int VSAMPLE_MS = 1000;
  localparam int VSAMPLE_CYC = (CLK_HZ / 1000) * VSAMPLE_MS;
  // ***************************************
  // Scaling
  // ***************************************
  localparam int FINAL_EMPTY_WARNING_MV = 25;
  localparam int FULL_SCALE_MV = 1200;
  localparam int VOLT_STEPS = 256;
  localparam logic [8:0] FINAL_EMPTY_WARNING_STEPS = 9'(FINAL_EMPTY_WARNING_MV * VOLT_STEPS / FULL_SCALE_MV);
  localparam logic [15:0] KEEP_PCT = 16'h005E;
  localparam logic [15:0] FULL_PCT = 16'h0064;
  localparam logic [7:0] CPI_MAX = 8'hFF;
  localparam logic [7:0] CI_COUNT = 8'h40;
  localparam logic [3:0] TEMP_MAX = 4'hC;
  localparam logic [3:0] TEMP_ZERO = 4'h4;
  localparam logic [3:0] TEMP_TEN = 4'h5;
  localparam logic [4:0] FILL_SCALE = 5'h10;
  localparam logic [3:0] FILL_MAX = 4'hF;
  localparam logic [4:0] SEG_SCALE = 5'h05;
  localparam int SEG_N = 5;
  // ***************************************
  // Register map and reset values
  // ***************************************
  localparam logic [6:0] A_FLAGS1 = 7'h01;
  localparam logic [6:0] A_TEMP = 7'h02;
  localparam logic [6:0] A_NAC_HI = 7'h03;
  localparam logic [6:0] A_PACK_ID = 7'h04;
  localparam logic [6:0] A_FULL_REF = 7'h05;
  localparam logic [6:0] A_FLAGS2 = 7'h06;
  localparam logic [6:0] A_PIN_DN = 7'h07;
  localparam logic [6:0] A_PIN_UP = 7'h08;
  localparam logic [6:0] A_CPI = 7'h09;
  localparam logic [6:0] A_VOLT = 7'h0B;
  localparam logic [6:0] A_THRESH = 7'h0C;
  localparam logic [6:0] A_TEMP_RATE_COMP_CAPACITY = 7'h0D;
  localparam logic [6:0] A_RATE_COMP_CAPACITY = 7'h0E;
  localparam logic [6:0] A_NAC_LO = 7'h17;
  localparam logic [7:0] THRESH_RST = 8'hA2;
  localparam logic [7:0] NAC_RST = 8'h00;
  localparam logic CI_RST = 1'b1;
  // ***************************************
  // Carriers
  // ***************************************
  typedef enum logic [1:0] {RATE_LOW, RATE_MID, RATE_HIGH} gsr_rate_t;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } gsr_cmd_t;
  typedef struct packed {
    logic [7:0] volt;
    gsr_rate_t rate;
    logic [3:0] temp;
    logic [7:0] comp_cap;
    logic [7:0] temp_comp_cap;
    logic [7:0] disch_count;
    logic [7:0] full_count;
    logic [4:0] pin_dn;
    logic [4:0] pin_up;
  } gsr_meas_t;
  typedef struct packed {
    logic charge;
    logic disch;
    logic self_disch;
    logic valid_charge;
  } gsr_ev_t;
endpackage

// [hw/gsr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: Low voltage under 2C latches first warning
// RQ2: First warning blinks segment one at 4Hz
// RQ3: 25mV lower latches final warning
// RQ4: Final warning turns all segments off
// RQ5: Upper nibble holds clamped temperature code
// RQ6: Lower nibble holds fill in sixteenths
// RQ7: Nominal capacity counts charge and discharge
// RQ8: Host keeps nominal capacity within reference
// RQ9: Full reference loads count, floor 0.94
// RQ10: Host never writes reserved flag bits
// RQ11: Flag bits 6-4 report discharge regime; the code reports it in bits 5-4 and holds bit 6 at zero
// RQ12: Valid-charge flag set, cleared from full
// RQ13: Overload flag, 0.5s hold, stops sampling
// RQ14: Pin maps in bits 4-0, upper zero
// RQ15: Charge count saturates, once above 0.94
// RQ16: Count 64 flags stale; update clears both
// RQ17: Update only after clean full-to-empty
// RQ18: Cell voltage refreshed once per second
// RQ19: Threshold register resets to A2h
// RQ20: Compensated capacity never rises in discharge
// RQ21: Temperature-reduced capacity drives the display
// RQ22: Host ignores the activity test bit
// RQ23: Command bit 7 writes, bits 6-0 address
module gsr_regs
  import gsr_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int OVL_CYC = OVL_HOLD_CYC,
  parameter int VS_CYC = VSAMPLE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire gsr_cmd_t host_cmd,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire gsr_meas_t meas,
  input wire gsr_ev_t ev,
  input wire logic disp_en,
  output logic [SEG_N-1:0] segment_out,
  output logic first_empty_warning,
  output logic final_empty_warning,
  output logic overload_flag
);
  // ***************************************
  // Checks and helpers
  // ***************************************
  if (BLINK_CYC < 1 || OVL_CYC < 1 || VS_CYC < 1) begin : g_bad
    $error("gsr_regs: cycle counts must be at least one");
  end

  function automatic logic hit(input gsr_cmd_t c, input logic [6:0] a);
    return c.valid && c.wr && c.addr == a; // [RQ23]
  endfunction

  // Count of k in 1..top with num*scale >= k*den
  function automatic logic [3:0] steps(input logic [7:0] num, input logic [7:0] den,
                                       input logic [4:0] scale, input logic [3:0] top);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 1; k < 16; k++) begin
      if (4'(k) <= top && den != 8'h00 &&
          32'(num) * 32'(scale) >= 32'(k) * 32'(den)) begin
        n = 4'(k);
      end
    end
    return n;
  endfunction

  logic init_q;
  logic [$clog2(VS_CYC+1)-1:0] vs_cnt_q;
  logic tick_q;
  logic [7:0] volt_q, vts_q, lmd_q, cpi_q, id_q, rate_comp_capacity_q, temp_rate_comp_capacity_q, tmp_q;
  logic [15:0] nac_q, vdq_start_q;
  logic [$clog2(OVL_CYC+1)-1:0] ovl_cnt_q;
  logic ovl_q, first_empty_warning_q, final_empty_warning_q, vdq_q, vq_q, ci_q, cpi_blk_q, act_q;
  gsr_rate_t rate_q;
  logic [4:0] pdn_q, pup_q;
  logic [$clog2(BLINK_CYC+1)-1:0] blink_cnt_q;
  logic blink_q;
  logic [SEG_N-1:0] seg_q, seg_pat;
  logic rd_valid_q;
  logic [7:0] rd_data_q;

  logic [7:0] nac_hi, keep94, lmd_new;
  logic lmd_upd, above94, cpi_inc, from_full, first_empty_warning_set, final_empty_warning_set, self_big;
  logic [3:0] seg_cnt;

  assign nac_hi = nac_q[15:8];
  assign keep94 = 8'((16'(lmd_q) * KEEP_PCT) / FULL_PCT);
  assign lmd_upd = init_q && ev.valid_charge && first_empty_warning_q && vdq_q; // [RQ9] [RQ17]
  assign lmd_new = (meas.disch_count < keep94) ? keep94 : meas.disch_count; // [RQ9]
  assign above94 = nac_hi > keep94;
  assign cpi_inc = ev.valid_charge && !(above94 && cpi_blk_q); // [RQ15]
  assign from_full = ev.disch && nac_hi == lmd_q;
  assign first_empty_warning_set = tick_q && !ovl_q && meas.rate != RATE_HIGH
                    && meas.volt < vts_q; // [RQ1] [RQ13]
  assign final_empty_warning_set = tick_q && !ovl_q && meas.rate != RATE_HIGH
                    && {1'b0, meas.volt} + FINAL_EMPTY_WARNING_STEPS < {1'b0, vts_q}; // [RQ3]
  assign self_big = ev.self_disch &&
                    32'(nac_q) * 32'(FULL_PCT) < 32'(vdq_start_q) * 32'(KEEP_PCT);

  // ***************************************
  // Start-up and sampling
  // ***************************************
  // Reset value of the reference is a live input, so it loads after release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vs_cnt_q <= '0;
      tick_q <= 1'b0;
      volt_q <= 8'h00;
    end else begin
      tick_q <= 1'b0;
      if (vs_cnt_q == ($bits(vs_cnt_q))'(VS_CYC - 1)) begin
        vs_cnt_q <= '0;
        tick_q <= 1'b1;
        volt_q <= meas.volt; // [RQ18]
      end else begin
        vs_cnt_q <= vs_cnt_q + ($bits(vs_cnt_q))'(1);
      end
    end
  end

  // ***************************************
  // Overload and rate
  // ***************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovl_q <= 1'b0;
      ovl_cnt_q <= '0;
    end else if (meas.rate == RATE_HIGH) begin
      ovl_q <= 1'b1; // [RQ13]
      ovl_cnt_q <= '0;
    end else if (ovl_q) begin
      if (ovl_cnt_q == ($bits(ovl_cnt_q))'(OVL_CYC - 1)) begin
        ovl_q <= 1'b0; // [RQ13]
        ovl_cnt_q <= '0;
      end else begin
        ovl_cnt_q <= ovl_cnt_q + ($bits(ovl_cnt_q))'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_q <= RATE_LOW;
      act_q <= 1'b0;
      pdn_q <= 5'h00;
      pup_q <= 5'h00;
      tmp_q <= 8'h00;
    end else begin
      rate_q <= meas.rate; // [RQ11]
      act_q <= ev.charge | ev.disch;
      pdn_q <= meas.pin_dn; // [RQ14]
      pup_q <= meas.pin_up; // [RQ14]
      tmp_q <= {(meas.temp > TEMP_MAX) ? TEMP_MAX : meas.temp, // [RQ5]
                steps(temp_rate_comp_capacity_q, lmd_q, FILL_SCALE, FILL_MAX)}; // [RQ6]
    end
  end

  // ***************************************
  // Empty warnings
  // ***************************************
  // Set beats a same-cycle valid charge, so a late low sample is not lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_empty_warning_q <= 1'b0;
      final_empty_warning_q <= 1'b0;
    end else begin
      if (first_empty_warning_set) first_empty_warning_q <= 1'b1; // [RQ1]
      else if (ev.valid_charge) first_empty_warning_q <= 1'b0; // [RQ1]
      if (final_empty_warning_set) final_empty_warning_q <= 1'b1; // [RQ3]
      else if (ev.valid_charge) final_empty_warning_q <= 1'b0; // [RQ3]
    end
  end

  // ***************************************
  // Nominal capacity
  // ***************************************
  // Host writes trust the caller to stay within the reference
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nac_q <= {NAC_RST, NAC_RST}; // [RQ7]
    end else if (hit(host_cmd, A_NAC_HI)) begin
      nac_q[15:8] <= host_cmd.wdata; // [RQ8]
    end else if (hit(host_cmd, A_NAC_LO)) begin
      nac_q[7:0] <= host_cmd.wdata; // [RQ8]
    end else if (ev.charge && nac_q != 16'hFFFF) begin
      nac_q <= nac_q + 16'h0001; // [RQ7]
    end else if ((ev.disch || ev.self_disch) && nac_q != 16'h0000) begin
      nac_q <= nac_q - 16'h0001; // [RQ7]
    end
  end

  // ***************************************
  // Full reference and charge count
  // ***************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lmd_q <= 8'h00;
    end else if (!init_q) begin
      lmd_q <= meas.full_count;
    end else if (lmd_upd) begin
      lmd_q <= lmd_new; // [RQ9]
    end else if (hit(host_cmd, A_FULL_REF)) begin
      lmd_q <= host_cmd.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpi_q <= 8'h00;
      ci_q <= CI_RST;
      cpi_blk_q <= 1'b0;
    end else begin
      if (lmd_upd) begin
        cpi_q <= 8'h00; // [RQ16]
        ci_q <= 1'b0; // [RQ16]
      end else begin
        if (hit(host_cmd, A_CPI)) cpi_q <= host_cmd.wdata;
        else if (cpi_inc && cpi_q != CPI_MAX) cpi_q <= cpi_q + 8'h01; // [RQ15]
        if (cpi_inc && cpi_q == CI_COUNT - 8'h01) ci_q <= 1'b1; // [RQ16]
      end
      if (ev.valid_charge && above94) cpi_blk_q <= 1'b1; // [RQ15]
      else if (nac_hi < keep94) cpi_blk_q <= 1'b0; // [RQ15]
    end
  end

  // ***************************************
  // Discharge qualification
  // ***************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vdq_q <= 1'b0;
      vdq_start_q <= 16'h0000;
      vq_q <= 1'b0;
    end else begin
      if (from_full) begin
        vdq_q <= 1'b1; // [RQ17]
        vdq_start_q <= nac_q;
      end else if (lmd_upd || ev.valid_charge || self_big ||
                   (first_empty_warning_set && meas.temp < TEMP_ZERO)) begin
        vdq_q <= 1'b0; // [RQ17]
      end
      if (ev.valid_charge) vq_q <= 1'b1; // [RQ12]
      else if (from_full) vq_q <= 1'b0; // [RQ12]
    end
  end

  // ***************************************
  // Compensated capacity
  // ***************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_comp_capacity_q <= 8'h00;
      temp_rate_comp_capacity_q <= 8'h00;
    end else begin
      if (hit(host_cmd, A_RATE_COMP_CAPACITY)) rate_comp_capacity_q <= host_cmd.wdata;
      else if (ev.charge) rate_comp_capacity_q <= nac_hi; // [RQ20]
      else if (ev.disch && meas.comp_cap < rate_comp_capacity_q) rate_comp_capacity_q <= meas.comp_cap; // [RQ20]
      if (hit(host_cmd, A_TEMP_RATE_COMP_CAPACITY)) temp_rate_comp_capacity_q <= host_cmd.wdata;
      else if (meas.temp < TEMP_TEN && meas.temp_comp_cap < rate_comp_capacity_q)
        temp_rate_comp_capacity_q <= meas.temp_comp_cap; // [RQ21]
      else temp_rate_comp_capacity_q <= rate_comp_capacity_q; // [RQ21]
    end
  end

  // ***************************************
  // Host writable plain registers
  // ***************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vts_q <= THRESH_RST; // [RQ19]
      id_q <= 8'h00;
    end else begin
      if (hit(host_cmd, A_THRESH)) vts_q <= host_cmd.wdata; // [RQ19]
      if (hit(host_cmd, A_PACK_ID)) id_q <= host_cmd.wdata;
    end
  end

  // ***************************************
  // Segment display
  // ***************************************
  assign seg_cnt = steps(temp_rate_comp_capacity_q, lmd_q, SEG_SCALE, 4'(SEG_N));
  for (genvar i = 0; i < SEG_N; i++) begin : g_seg
    assign seg_pat[i] = seg_cnt > 4'(i); // [RQ21]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == ($bits(blink_cnt_q))'(BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_q <= ~blink_q; // [RQ2]
    end else begin
      blink_cnt_q <= blink_cnt_q + ($bits(blink_cnt_q))'(1);
    end
  end

  // Bank multiplexing is left to the pad driver
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_q <= '0;
    end else if (final_empty_warning_q || !disp_en) begin
      seg_q <= '0; // [RQ4]
    end else begin
      seg_q <= {seg_pat[SEG_N-1:1], first_empty_warning_q ? blink_q : seg_pat[0]}; // [RQ2]
    end
  end

  // ***************************************
  // Host reads
  // ***************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_valid_q <= host_cmd.valid && !host_cmd.wr; // [RQ23]
      case (host_cmd.addr)
        A_FLAGS1: rd_data_q <= {3'b000, ci_q, vdq_q, 1'b1, first_empty_warning_q, final_empty_warning_q};
        A_TEMP: rd_data_q <= tmp_q;
        A_NAC_HI: rd_data_q <= nac_q[15:8];
        A_NAC_LO: rd_data_q <= nac_q[7:0];
        A_PACK_ID: rd_data_q <= id_q;
        A_FULL_REF: rd_data_q <= lmd_q;
        A_FLAGS2: rd_data_q <= {1'b0, 1'b0, rate_q, act_q, vq_q, 1'b0, ovl_q}; // [RQ11] [RQ22]
        A_PIN_DN: rd_data_q <= {3'b000, pdn_q}; // [RQ14]
        A_PIN_UP: rd_data_q <= {3'b000, pup_q}; // [RQ14]
        A_CPI: rd_data_q <= cpi_q;
        A_VOLT: rd_data_q <= volt_q;
        A_THRESH: rd_data_q <= vts_q;
        A_TEMP_RATE_COMP_CAPACITY: rd_data_q <= temp_rate_comp_capacity_q;
        A_RATE_COMP_CAPACITY: rd_data_q <= rate_comp_capacity_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
  assign segment_out = seg_q;
  assign first_empty_warning = first_empty_warning_q;
  assign final_empty_warning = final_empty_warning_q;
  assign overload_flag = ovl_q;

  // ***************************************
  // Assertions
  // ***************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_low_sample;
    tick_q && !ovl_q && meas.rate != RATE_HIGH && meas.volt < vts_q;
  endsequence

  a_first_empty_warning_sets: assert property (s_low_sample |=> first_empty_warning_q) // [RQ1]
    else $error("first warning missed a low sample");
  a_first_empty_warning_holds: assert property (first_empty_warning_q && !ev.valid_charge |=> first_empty_warning_q) // [RQ1]
    else $error("first warning dropped without charge");
  a_final_empty_warning_holds: assert property (final_empty_warning_q && !ev.valid_charge |=> final_empty_warning_q) // [RQ3]
    else $error("final warning dropped without charge");
  a_final_empty_warning_dark: assert property (final_empty_warning_q |=> seg_q == '0) // [RQ4]
    else $error("segments lit under final warning");
  a_ovl_follow: assert property (meas.rate == RATE_HIGH |=> ovl_q [*2]) // [RQ13]
    else $error("overload not held");
  a_nac_step: assert property (ev.charge && !host_cmd.valid && nac_q != 16'hFFFF
    |=> nac_q == $past(nac_q) + 16'h0001) // [RQ7]
    else $error("capacity did not count up");
  a_lmd_floor: assert property (lmd_upd |=> lmd_q >= $past(keep94)) // [RQ9]
    else $error("reference below floor");
  a_cpi_clear: assert property (lmd_upd |=> cpi_q == 8'h00 && !ci_q) // [RQ16]
    else $error("count or stale flag not cleared");
  a_cpi_sat: assert property (cpi_q == CPI_MAX && !lmd_upd && !host_cmd.valid
    |=> cpi_q == CPI_MAX) // [RQ15]
    else $error("charge count rolled over");
  a_rate_comp_capacity_fall: assert property (ev.disch && !ev.charge && !host_cmd.valid
    |=> rate_comp_capacity_q <= $past(rate_comp_capacity_q)) // [RQ20]
    else $error("compensated capacity rose in discharge");
endmodule
`default_nettype wire

// [testbench/gsr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// *****
// Host side of the command port
// *****
module gsr_host_model
  import gsr_pkg::*;
(
  input wire logic clk,
  output gsr_cmd_t host_cmd,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  initial host_cmd = '0;

  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    // Second flag register holds reserved bits, so the host never writes it
    if (a == A_FLAGS2) return;
    @(posedge clk);
    host_cmd <= '{valid: 1'b1, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    host_cmd.valid <= 1'b0;
  endtask

  // Bounded wait, so a silent design cannot hang the host
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    host_cmd <= '{valid: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      host_cmd.valid <= 1'b0;
      #1;
      if (rd_valid === 1'b1) begin
        d = rd_data;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// [testbench/gas_gauge_status_registers_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module gas_gauge_status_registers_bench
  import gsr_pkg::*;
;
  // *****
  // Short counts keep the run brief
  // *****
  localparam int BLINK = 4;
  localparam int OVL = 10;
  localparam int VS = 8;
  logic clk, sys_rst, disp_en, rd_valid;
  logic first_empty_warning, final_empty_warning, overload_flag;
  logic [7:0] rd_data;
  logic [SEG_N-1:0] segment_out;
  gsr_cmd_t host_cmd;
  gsr_meas_t meas;
  gsr_ev_t ev;
  int miscompares, checks_done, tog, lit;

  gsr_regs #(.BLINK_CYC(BLINK), .OVL_CYC(OVL), .VS_CYC(VS)) uut (
    .clk(clk), .sys_rst(sys_rst), .host_cmd(host_cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .meas(meas), .ev(ev), .disp_en(disp_en),
    .segment_out(segment_out), .first_empty_warning(first_empty_warning),
    .final_empty_warning(final_empty_warning), .overload_flag(overload_flag)
  );
  gsr_host_model host (
    .clk(clk), .host_cmd(host_cmd), .rd_valid(rd_valid), .rd_data(rd_data)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // *****
  // Helpers
  // *****
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] exp,
                      input string msg);
    logic [7:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    if (!ok) begin
      miscompares++;
      $display("wrong value at %0t: read timed out", $time);
      final_report();
    end else begin
      chk8(d & m, exp, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= gsr_ev_t'(m);
    @(posedge clk);
    ev <= '0;
  endtask

  task automatic watch;
    logic p;
    tog = 0;
    lit = 0;
    p = segment_out[0];
    repeat (16) begin
      @(posedge clk);
      #1;
      if (segment_out[0] !== p) tog++;
      p = segment_out[0];
      if (segment_out !== '0) lit++;
    end
  endtask

  // Full-to-empty pass ending in a reference update
  task automatic upd(input logic [7:0] r, input logic [7:0] cnt, input logic [7:0] exp);
    host.write_reg(A_NAC_HI, r);
    pulse(4'b0100);
    rchk(A_FLAGS1, 8'h08, 8'h08, "valid discharge");
    rchk(A_FLAGS2, 8'h04, 8'h00, "charge flag clear");
    @(posedge clk);
    meas.volt <= 8'hA0;
    meas.disch_count <= cnt;
    cyc(VS + 4);
    @(posedge clk) meas.volt <= 8'hFF;
    pulse(4'b0001);
    rchk(A_FULL_REF, 8'hFF, exp, "reference update");
    rchk(A_FLAGS1, 8'h10, 8'h00, "stale clear");
  endtask

  // *****
  // Main sequence
  // *****
  initial begin
    sys_rst = 1'b1;
    disp_en = 1'b1;
    ev = '0;
    miscompares = 0;
    checks_done = 0;
    meas = '{volt: 8'hFF, rate: RATE_LOW, temp: 4'h7, comp_cap: 8'h40, temp_comp_cap: 8'h40,
             disch_count: 8'h00, full_count: 8'h80, pin_dn: 5'h09, pin_up: 5'h14};
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(2);
    rchk(A_THRESH, 8'hFF, THRESH_RST, "threshold reset");
    rchk(A_NAC_HI, 8'hFF, NAC_RST, "nac high reset");
    rchk(A_NAC_LO, 8'hFF, NAC_RST, "nac low reset");
    rchk(A_FULL_REF, 8'hFF, 8'h80, "reference reset");
    rchk(A_FLAGS1, 8'h1F, 8'h14, "flags reset");
    host.write_reg(A_THRESH, 8'h80);
    rchk(A_THRESH, 8'hFF, 8'h80, "threshold write");
    host.write_reg(A_THRESH, THRESH_RST);
    host.write_reg(A_PACK_ID, 8'h5A);
    rchk(A_PACK_ID, 8'hFF, 8'h5A, "pack id");
    host.write_reg(A_PIN_DN, 8'hFF);
    rchk(A_PIN_DN, 8'hFF, 8'h09, "pull-down map");
    rchk(A_PIN_UP, 8'hFF, 8'h14, "pull-up map");
    rchk(7'h7F, 8'hFF, 8'h00, "unmapped read");
    $display("test registers done");

    // Fill follows the compensated capacity, which is zero after reset
    host.write_reg(A_RATE_COMP_CAPACITY, 8'h40);
    cyc(3);
    rchk(A_TEMP, 8'hFF, 8'h78, "temp and fill");
    host.write_reg(A_RATE_COMP_CAPACITY, 8'h80);
    @(posedge clk);
    meas.temp <= 4'hF;
    cyc(3);
    rchk(A_TEMP, 8'hFF, {TEMP_MAX, FILL_MAX}, "temp clamp");
    @(posedge clk);
    meas.temp <= 4'h3;
    meas.temp_comp_cap <= 8'h20;
    meas.comp_cap <= 8'h40;
    cyc(3);
    rchk(A_TEMP_RATE_COMP_CAPACITY, 8'hFF, 8'h20, "cold capacity");
    rchk(A_TEMP, 8'hFF, 8'h34, "cold fill");
    chk8({3'b000, segment_out}, 8'h01, "cold display");
    @(posedge clk) disp_en <= 1'b0;
    cyc(2);
    chk8({3'b000, segment_out}, 8'h00, "display off");
    @(posedge clk) disp_en <= 1'b1;
    @(posedge clk) meas.temp <= 4'h7;
    $display("test temperature done");

    for (int r = 0; r < 3; r++) begin
      @(posedge clk) meas.rate <= gsr_rate_t'(r);
      cyc(2);
      // Activity bit masked off, its value is not defined
      rchk(A_FLAGS2, 8'h70, {2'b00, 2'(r), 4'h0}, "rate code");
    end
    rchk(A_FLAGS2, 8'h01, 8'h01, "overload bit");
    @(posedge clk) meas.volt <= 8'hA0;
    cyc(VS + 4);
    chk1(first_empty_warning, 1'b0, "sampling held");
    @(posedge clk) meas.volt <= 8'hFF;
    @(posedge clk) meas.rate <= RATE_LOW;
    cyc(OVL / 2);
    chk1(overload_flag, 1'b1, "overload hold");
    cyc(OVL);
    chk1(overload_flag, 1'b0, "overload release");
    $display("test rate done");

    repeat (3) pulse(4'b1000);
    rchk(A_NAC_LO, 8'hFF, 8'h03, "nac charge");
    pulse(4'b0100);
    pulse(4'b0010);
    rchk(A_NAC_LO, 8'hFF, 8'h01, "nac discharge");
    $display("test capacity done");

    @(posedge clk) meas.volt <= 8'hA0;
    cyc(VS + 4);
    chk1(first_empty_warning, 1'b1, "first warning");
    chk1(final_empty_warning, 1'b0, "final above");
    rchk(A_VOLT, 8'hFF, 8'hA0, "cell voltage");
    watch();
    chk1(tog >= 2, 1'b1, "segment blink");
    @(posedge clk) meas.volt <= 8'h9C;
    cyc(VS + 4);
    chk1(final_empty_warning, 1'b1, "final warning");
    watch();
    chk1(lit == 0, 1'b1, "segments off");
    @(posedge clk) meas.volt <= 8'hFF;
    cyc(VS + 4);
    chk1(first_empty_warning, 1'b1, "first latched");
    pulse(4'b0001);
    cyc(2);
    rchk(A_FLAGS1, 8'h03, 8'h00, "warnings clear");
    rchk(A_FLAGS2, 8'h04, 8'h04, "valid charge");
    $display("test warnings done");

    upd(8'h80, 8'h7A, 8'h7A);
    upd(8'h7A, 8'h10, 8'(16'h007A * KEEP_PCT / FULL_PCT));
    $display("test reference done");

    host.write_reg(A_NAC_HI, 8'h00);
    host.write_reg(A_CPI, 8'h3F);
    pulse(4'b0001);
    rchk(A_CPI, 8'hFF, CI_COUNT, "count step");
    rchk(A_FLAGS1, 8'h10, 8'h10, "stale set");
    host.write_reg(A_CPI, CPI_MAX);
    pulse(4'b0001);
    rchk(A_CPI, 8'hFF, CPI_MAX, "count saturate");
    host.write_reg(A_NAC_HI, 8'h72);
    host.write_reg(A_CPI, 8'h05);
    pulse(4'b0001);
    pulse(4'b0001);
    rchk(A_CPI, 8'hFF, 8'h06, "count once near full");
    $display("test count done");
    final_report();
  end
endmodule
`default_nettype wire
